// [ecl_eeprom_model.sv]
`timescale 1ns/1ns
module ecl_eeprom_model (
    // Clock
    input wire logic i_clock,
    // Word stream
    output logic o_word_valid,
    output ecl_pkg::ecl_word_type o_word,
    output logic o_load_end
);
    initial begin
        o_word_valid = 1'b0;
        o_word = '0;
        o_load_end = 1'b0;
    end
    // Bus shows inverted junk between words, never the last value
    task automatic send(input logic [7:0] a, input logic [15:0] dt);
        @(posedge i_clock);
        o_word_valid <= 1'b1;
        o_word <= {a, dt};
        @(posedge i_clock);
        o_word_valid <= 1'b0;
        o_word <= ~{a, dt};
    endtask
    task automatic finish();
        @(posedge i_clock);
        o_load_end <= 1'b1;
        @(posedge i_clock);
        o_load_end <= 1'b0;
    endtask
endmodule

// [ecl_loader.sv]
`timescale 1ns/1ns

// Notes on behaviour
// - Word 42h bits 15:14 go to port 1 TL control bits 9:8.
// - Word 44h bits 4:0 go to port 2 PHY parameter 2 bits 12:8.
// - Word 44h bits 11:5 go to port 2 PHY parameter 3 bits 6:0.
// - Word 44h bit 12 sets port 2 selectable de-emphasis, F0h bit 6.
// - Word 44h bit 13 sets port 2 compliance-to-detect, 78h bit 11.
// - Word 44h bits 15:14 go to port 2 TL control bits 9:8.
// - Word 50h bit 0 sets port 0 no-soft-reset, 44h bit 3.
// - Word 50h bits 3:1 give port 0 aux current, 40h bits 24:22.
// - PM word bits 4,5 give D1/D2 support, 40h bits 25,26, read only.
// - PM word bits 7:6 give PME support for D2/D1, 40h bits 29:28.
// - Word 51h bits 15:8 give port 0 PM data byte, 44h bits 31:24.
// - Words 52h/53h load port 1, 54h/55h port 2, same positions.
// - Word 60h bit 1 sets port 0 slot clock, D0h bit 28.
// - Word 60h bit 2 sets port 0 device-specific init, 40h bit 21.
// - Word 60h bit 3 sets port 0 low-priority VC count, 144h bit 4.
// - Word 60h bits 6:4 give port 0 logical port number, CCh 26:24.
module ecl_loader #(
    parameter int APB_ADDR_W = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // EEPROM word stream
    input wire logic i_eeprom_present,
    input wire logic i_word_valid,
    input wire ecl_pkg::ecl_word_type i_word,
    input wire logic i_load_end,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_ADDR_W-1:0] i_paddr,
    input wire logic [ecl_pkg::DATA_W-1:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [ecl_pkg::DATA_W-1:0] o_prdata,
    // Loaded configuration towards the switch core
    output logic o_load_done,
    output ecl_pkg::ecl_port_cfg_type [ecl_pkg::NUM_PORTS-1:0] o_port_cfg
);

    if (APB_ADDR_W < 16) begin : g_check_addr
        $error("APB_ADDR_W must be at least 16");
    end

    // Which port a power-management word belongs to
    function automatic logic [ecl_pkg::PORT_W-1:0] pm_port(
        input logic [ecl_pkg::WADDR_W-1:0] addr
    );
        logic [ecl_pkg::WADDR_W-1:0] rel;
        rel = addr - ecl_pkg::WORD_PM_FIRST;
        return rel[ecl_pkg::PORT_W:1];
    endfunction

    function automatic logic cfg_mapped(input logic [ecl_pkg::CFG_OFF_W-1:0] off);
        case (off)
            ecl_pkg::CFG_PM_CAP, ecl_pkg::CFG_PM_CSR, ecl_pkg::CFG_PHY_CSR2,
            ecl_pkg::CFG_PHY_PARAM2, ecl_pkg::CFG_TL_CTRL, ecl_pkg::CFG_PHY_PARAM3,
            ecl_pkg::CFG_PORT_NUM, ecl_pkg::CFG_LINK_STAT, ecl_pkg::CFG_DEEMPH,
            ecl_pkg::CFG_VC_CAP: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Assembles one configuration dword from a port's loaded fields
    function automatic logic [ecl_pkg::DATA_W-1:0] cfg_read(
        input ecl_pkg::ecl_port_cfg_type p,
        input logic [ecl_pkg::CFG_OFF_W-1:0] off
    );
        logic [ecl_pkg::DATA_W-1:0] r;
        r = '0;
        case (off)
            ecl_pkg::CFG_PM_CAP: begin
                r[ecl_pkg::DSI_BIT] = p.dsi_required;
                r[ecl_pkg::AUX_LSB +: 3] = p.aux_current;
                r[ecl_pkg::D1_BIT] = p.d1_support;
                r[ecl_pkg::D2_BIT] = p.d2_support;
                r[ecl_pkg::PME_LSB +: 2] = p.pme_support;
            end
            ecl_pkg::CFG_PM_CSR: begin
                r[ecl_pkg::NSR_BIT] = p.no_soft_reset;
                r[ecl_pkg::PMDATA_LSB +: 8] = p.pm_data;
            end
            ecl_pkg::CFG_PHY_CSR2: r[ecl_pkg::COMP_BIT] = p.compliance_to_detect;
            ecl_pkg::CFG_PHY_PARAM2: r[ecl_pkg::PHY2_LSB +: 5] = p.phy_param2;
            ecl_pkg::CFG_TL_CTRL: r[ecl_pkg::DCS_LSB +: 2] = p.data_count_change_select;
            ecl_pkg::CFG_PHY_PARAM3: r[ecl_pkg::PHY3_LSB +: 7] = p.phy_param3;
            ecl_pkg::CFG_PORT_NUM: r[ecl_pkg::PNUM_LSB +: 3] = p.port_number;
            ecl_pkg::CFG_LINK_STAT: r[ecl_pkg::SLOTCLK_BIT] = p.slot_clock;
            ecl_pkg::CFG_DEEMPH: r[ecl_pkg::DEEMPH_BIT] = p.deemph_select;
            ecl_pkg::CFG_VC_CAP: r[ecl_pkg::LOW_PRIORITY_VC_COUNT_BIT] = p.low_priority_vc_count;
            default: r = '0;
        endcase
        return r;
    endfunction

    // Loader state
    ecl_pkg::ecl_state_type state;
    ecl_pkg::ecl_state_type next_state;
    ecl_pkg::ecl_port_cfg_type [ecl_pkg::NUM_PORTS-1:0] cfg;
    ecl_pkg::ecl_port_cfg_type [ecl_pkg::NUM_PORTS-1:0] next_cfg;
    logic [ecl_pkg::CNT_W-1:0] word_count;
    logic [ecl_pkg::CNT_W-1:0] next_word_count;
    logic present;
    logic next_present;

    // APB state
    logic [ecl_pkg::DATA_W-1:0] prdata;
    logic [ecl_pkg::DATA_W-1:0] next_prdata;

    // Address decode
    logic [15:0] addr16;
    logic is_ctrl;
    logic is_status;
    logic is_cfg;
    logic [ecl_pkg::PORT_W-1:0] cfg_port;
    logic [ecl_pkg::CFG_OFF_W-1:0] cfg_off;
    logic reload;
    logic done;

    assign addr16 = i_paddr[15:0];
    assign cfg_port = addr16[11:10];
    assign cfg_off = addr16[9:0];
    assign is_ctrl = (addr16 == ecl_pkg::ADDR_CTRL);
    assign is_status = (addr16 == ecl_pkg::ADDR_STATUS);
    assign is_cfg = (addr16[15:12] == ecl_pkg::CFG_REGION)
        && (cfg_port < ecl_pkg::PORT_W'(ecl_pkg::NUM_PORTS))
        && cfg_mapped(cfg_off);
    assign done = (state == ecl_pkg::ECL_DONE);

    // Configuration window waits until loading is over
    assign o_pready = i_psel && i_penable && (!is_cfg || done);
    assign o_pslverr = o_pready && !(is_ctrl || is_status || is_cfg);
    assign reload = o_pready && i_pwrite && is_ctrl && i_pwdata[ecl_pkg::CTRL_RELOAD_BIT];

    always_comb begin
        logic [ecl_pkg::PORT_W-1:0] pp;
        logic [ecl_pkg::WDATA_W-1:0] d;
        pp = pm_port(i_word.addr);
        d = i_word.data;
        next_state = state;
        next_cfg = cfg;
        next_word_count = word_count;
        next_present = present;
        unique case (state)
            ecl_pkg::ECL_START: begin
                // Strap sampled after reset release; absent EEPROM keeps defaults
                next_present = i_eeprom_present;
                next_cfg = {ecl_pkg::NUM_PORTS{ecl_pkg::CFG_DEFAULT}};
                next_word_count = '0;
                next_state = i_eeprom_present ? ecl_pkg::ECL_LOAD : ecl_pkg::ECL_DONE;
            end
            ecl_pkg::ECL_LOAD: begin
                if (i_word_valid) begin
                    next_word_count = word_count + 1'b1;
                    if (i_word.addr == ecl_pkg::WORD_P1_PHY) begin
                        next_cfg[1].data_count_change_select = d[15:14];
                    end
                    if (i_word.addr == ecl_pkg::WORD_P2_PHY) begin
                        next_cfg[2].phy_param2 = d[4:0];
                        next_cfg[2].phy_param3 = d[11:5];
                        next_cfg[2].deemph_select = d[12];
                        next_cfg[2].compliance_to_detect = d[13];
                        next_cfg[2].data_count_change_select = d[15:14];
                    end
                    if (i_word.addr >= ecl_pkg::WORD_PM_FIRST
                            && i_word.addr <= ecl_pkg::WORD_PM_LAST) begin
                        // Even word: capability fields, odd word: data byte
                        if (!i_word.addr[0]) begin
                            next_cfg[pp].no_soft_reset = d[0];
                            next_cfg[pp].aux_current = d[3:1];
                            next_cfg[pp].d1_support = d[4];
                            next_cfg[pp].d2_support = d[5];
                            next_cfg[pp].pme_support = d[7:6];
                        end else begin
                            next_cfg[pp].pm_data = d[15:8];
                        end
                    end
                    if (i_word.addr == ecl_pkg::WORD_P0_CAP) begin
                        next_cfg[0].slot_clock = d[1];
                        next_cfg[0].dsi_required = d[2];
                        next_cfg[0].low_priority_vc_count = d[3];
                        next_cfg[0].port_number = d[6:4];
                    end
                end
                // A word beside the end marker is still taken
                if (i_load_end) begin
                    next_state = ecl_pkg::ECL_DONE;
                end
            end
            ecl_pkg::ECL_DONE: begin
                next_state = ecl_pkg::ECL_DONE;
            end
            default: begin
                next_state = ecl_pkg::ECL_START;
            end
        endcase
        if (reload) begin
            next_state = ecl_pkg::ECL_START;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state <= ecl_pkg::ECL_START;
            cfg <= {ecl_pkg::NUM_PORTS{ecl_pkg::CFG_DEFAULT}};
            word_count <= '0;
            present <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            word_count <= next_word_count;
            present <= next_present;
        end
    end

    // Read data prepared every selected read cycle, so it is ready at the access phase
    always_comb begin
        next_prdata = '0;
        if (i_psel && !i_pwrite) begin
            if (is_status) begin
                next_prdata[ecl_pkg::STAT_DONE_BIT] = done;
                next_prdata[ecl_pkg::STAT_PRESENT_BIT] = present;
                next_prdata[ecl_pkg::STAT_CNT_LSB +: ecl_pkg::CNT_W] = word_count;
            end else if (is_cfg) begin
                // Next values, so a word taken beside the end marker is not missed
                next_prdata = cfg_read(next_cfg[cfg_port], cfg_off);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            prdata <= '0;
        end else begin
            prdata <= next_prdata;
        end
    end

    assign o_prdata = prdata;
    assign o_load_done = done;
    assign o_port_cfg = cfg;

endmodule

// [ecl_loader_monitor.sv]
`timescale 1ns/1ns
module ecl_loader_monitor #(
    parameter int APB_ADDR_W = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Word stream
    input wire logic i_eeprom_present,
    input wire logic i_word_valid,
    input wire ecl_pkg::ecl_word_type i_word,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [APB_ADDR_W-1:0] i_paddr,
    input wire logic o_pready,
    // Loaded configuration
    input wire logic o_load_done,
    input wire ecl_pkg::ecl_port_cfg_type [ecl_pkg::NUM_PORTS-1:0] o_port_cfg
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // Words after done are ignored, so only open loads count
    wire logic take = i_word_valid && !o_load_done;
    wire logic [15:0] d = i_word.data;
    wire logic [1:0] k = i_word.addr[2:1];
    property p_p1_dcs;
        take && i_word.addr == 8'h42 |=>
            o_port_cfg[1].data_count_change_select == $past(d[15:14]);
    endproperty
    a_p1_dcs: assert property (p_p1_dcs) else $error("p1 dcs");
    property p_p2_phy;
        take && i_word.addr == 8'h44 |=>
            {o_port_cfg[2].phy_param3, o_port_cfg[2].phy_param2} == $past(d[11:0]);
    endproperty
    a_p2_phy: assert property (p_p2_phy) else $error("p2 phy");
    property p_p2_ctl;
        take && i_word.addr == 8'h44 |=> {o_port_cfg[2].data_count_change_select,
            o_port_cfg[2].compliance_to_detect, o_port_cfg[2].deemph_select} == $past(d[15:12]);
    endproperty
    a_p2_ctl: assert property (p_p2_ctl) else $error("p2 ctl");
    property p_pm_cap;
        take && i_word.addr inside {8'h50, 8'h52, 8'h54} |=>
            o_port_cfg[$past(k)][21:14] == $past({d[0], d[3:1], d[4], d[5], d[7:6]});
    endproperty
    a_pm_cap: assert property (p_pm_cap) else $error("pm cap");
    property p_pm_data;
        take && i_word.addr inside {8'h51, 8'h53, 8'h55} |=>
            o_port_cfg[$past(k)].pm_data == $past(d[15:8]);
    endproperty
    a_pm_data: assert property (p_pm_data) else $error("pm data");
    property p_cap0;
        take && i_word.addr == 8'h60 |=> o_port_cfg[0][4:0] == $past({d[2], d[3], d[6:4]}) &&
            o_port_cfg[0].slot_clock == $past(d[1]);
    endproperty
    a_cap0: assert property (p_cap0) else $error("cap0");
    property p_rst;
        disable iff (1'b0) !i_resetn |=>
            !o_load_done && o_port_cfg == {3{ecl_pkg::CFG_DEFAULT}};
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_hold;
        i_psel && i_penable && i_paddr[15:12] == 4'h1 && i_paddr[11:10] != 2'b11 &&
            i_paddr[9:0] inside {10'h040, 10'h044, 10'h078, 10'h07C, 10'h08C, 10'h090,
            10'h0CC, 10'h0D0, 10'h0F0, 10'h144} && !o_load_done |-> !o_pready;
    endproperty
    a_hold: assert property (p_hold) else $error("early cfg");
    property p_nostrap;
        $rose(i_resetn) && !i_eeprom_present |-> ##[1:2] o_load_done;
    endproperty
    a_nostrap: assert property (p_nostrap) else $error("no eeprom");
    c_p2: cover property (take && i_word.addr == 8'h44);
    c_wait: cover property (i_psel && i_penable && !o_pready);
    c_done: cover property ($rose(o_load_done));
endmodule

bind ecl_loader ecl_loader_monitor #(.APB_ADDR_W(APB_ADDR_W)) i_mon (.i_clock, .i_resetn,
    .i_eeprom_present, .i_word_valid, .i_word, .i_psel, .i_penable, .i_paddr, .o_pready,
    .o_load_done, .o_port_cfg);

// [ecl_pkg.sv]
package ecl_pkg;

    // Geometry
    localparam int NUM_PORTS = 3;
    localparam int PORT_W = 2;
    localparam int WADDR_W = 8;
    localparam int WDATA_W = 16;
    localparam int DATA_W = 32;
    localparam int CFG_OFF_W = 10;
    localparam int CNT_W = 8;

    // EEPROM word addresses
    localparam logic [7:0] WORD_P1_PHY = 8'h42;
    localparam logic [7:0] WORD_P2_PHY = 8'h44;
    localparam logic [7:0] WORD_PM_FIRST = 8'h50;
    localparam logic [7:0] WORD_PM_LAST = 8'h55;
    localparam logic [7:0] WORD_P0_CAP = 8'h60;

    // Configuration space offsets inside one port window
    localparam logic [9:0] CFG_PM_CAP = 10'h040;
    localparam logic [9:0] CFG_PM_CSR = 10'h044;
    localparam logic [9:0] CFG_PHY_CSR2 = 10'h078;
    localparam logic [9:0] CFG_PHY_PARAM2 = 10'h07C;
    localparam logic [9:0] CFG_TL_CTRL = 10'h08C;
    localparam logic [9:0] CFG_PHY_PARAM3 = 10'h090;
    localparam logic [9:0] CFG_PORT_NUM = 10'h0CC;
    localparam logic [9:0] CFG_LINK_STAT = 10'h0D0;
    localparam logic [9:0] CFG_DEEMPH = 10'h0F0;
    localparam logic [9:0] CFG_VC_CAP = 10'h144;

    // Field positions in configuration space
    localparam int DSI_BIT = 21;
    localparam int AUX_LSB = 22;
    localparam int D1_BIT = 25;
    localparam int D2_BIT = 26;
    localparam int PME_LSB = 28;
    localparam int NSR_BIT = 3;
    localparam int PMDATA_LSB = 24;
    localparam int COMP_BIT = 11;
    localparam int PHY2_LSB = 8;
    localparam int DCS_LSB = 8;
    localparam int PHY3_LSB = 0;
    localparam int DEEMPH_BIT = 6;
    localparam int PNUM_LSB = 24;
    localparam int SLOTCLK_BIT = 28;
    localparam int LOW_PRIORITY_VC_COUNT_BIT = 4;

    // APB map: control, status, then one window per port
    localparam logic [15:0] ADDR_CTRL = 16'h0000;
    localparam logic [15:0] ADDR_STATUS = 16'h0004;
    localparam logic [3:0] CFG_REGION = 4'h1;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_PRESENT_BIT = 1;
    localparam int STAT_CNT_LSB = 8;

    typedef enum logic [2:0] {
        ECL_START = 3'b001,
        ECL_LOAD = 3'b010,
        ECL_DONE = 3'b100
    } ecl_state_type;

    typedef struct packed {
        logic [1:0] data_count_change_select;
        logic [4:0] phy_param2;
        logic [6:0] phy_param3;
        logic deemph_select;
        logic compliance_to_detect;
        logic no_soft_reset;
        logic [2:0] aux_current;
        logic d1_support;
        logic d2_support;
        logic [1:0] pme_support;
        logic [7:0] pm_data;
        logic slot_clock;
        logic dsi_required;
        logic low_priority_vc_count;
        logic [2:0] port_number;
    } ecl_port_cfg_type;

    typedef struct packed {
        logic [WADDR_W-1:0] addr;
        logic [WDATA_W-1:0] data;
    } ecl_word_type;

    // D1 and D2 support read as one until loaded otherwise
    localparam ecl_port_cfg_type CFG_DEFAULT = '{
        d1_support: 1'b1,
        d2_support: 1'b1,
        default: '0
    };

endpackage

// [eeprom_config_field_loader_test.sv]
`timescale 1ns/1ns
module eeprom_config_field_loader_test;
    logic clk, resetn, strap, psel, penable, pwrite, pready, pslverr, done, wv, lend, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pm [6];
    logic [15:0] w44 = 16'h7A5D;
    logic [15:0] w60 = 16'h005E;
    ecl_pkg::ecl_word_type word;
    int bad_count, num_checks;
    ecl_loader i_dut (.i_clock(clk), .i_resetn(resetn), .i_eeprom_present(strap),
        .i_word_valid(wv), .i_word(word), .i_load_end(lend), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .o_load_done(done),
        .o_port_cfg());
    ecl_eeprom_model i_rom (.i_clock(clk), .o_word_valid(wv), .o_word(word), .o_load_end(lend));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task chk_rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    function automatic logic [15:0] cfa(input int p, input logic [9:0] off);
        return 16'h1000 + 16'(p) * 16'h0400 + {6'h00, off};
    endfunction
    task do_reset(input logic s);
        strap <= s;
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask
    task t_empty;
        chk_rd(ecl_pkg::ADDR_STATUS, 32'h1);
        chk_rd(cfa(0, ecl_pkg::CFG_PM_CAP), 32'h0600_0000);
        apb(1'b1, ecl_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        chk_rd(ecl_pkg::ADDR_STATUS, 32'h1);
        for (int i = 0; i < 2; i++) begin
            chk_rd(i ? 16'h1C40 : 16'h2000, 32'h0);
            check({31'h0, err}, 32'h1);
        end
        $display("test empty done");
    endtask
    task t_load;
        logic [15:0] dv;
        logic [31:0] ev;
        do_reset(1'b1);
        fork
            chk_rd(cfa(1, ecl_pkg::CFG_TL_CTRL), 32'h0000_0100);
            begin
                i_rom.send(8'h42, 16'hC000);
                i_rom.send(8'h42, 16'h4000);
                i_rom.send(8'h44, w44);
                for (int i = 0; i < 6; i++) i_rom.send(8'(8'h50 + i), pm[i]);
                i_rom.send(8'h60, w60);
                i_rom.send(8'h70, 16'hFFFF);
                i_rom.finish();
            end
        join
        check({31'h0, done}, 32'h1);
        chk_rd(cfa(2, ecl_pkg::CFG_PHY_PARAM2), {19'h0, w44[4:0], 8'h0});
        chk_rd(cfa(2, ecl_pkg::CFG_PHY_PARAM3), {25'h0, w44[11:5]});
        chk_rd(cfa(2, ecl_pkg::CFG_DEEMPH), {25'h0, w44[12], 6'h0});
        chk_rd(cfa(2, ecl_pkg::CFG_PHY_CSR2), {20'h0, w44[13], 11'h0});
        chk_rd(cfa(2, ecl_pkg::CFG_TL_CTRL), {22'h0, w44[15:14], 8'h0});
        for (int p = 0; p < 3; p++) begin
            dv = pm[2 * p];
            ev = {2'h0, dv[7:6], 1'b0, dv[5], dv[4], dv[3:1], p == 0 && w60[2], 21'h0};
            chk_rd(cfa(p, ecl_pkg::CFG_PM_CAP), ev);
            ev = {pm[2 * p + 1][15:8], 20'h0, dv[0], 3'h0};
            chk_rd(cfa(p, ecl_pkg::CFG_PM_CSR), ev);
        end
        chk_rd(cfa(0, ecl_pkg::CFG_VC_CAP), {27'h0, w60[3], 4'h0});
        chk_rd(cfa(0, ecl_pkg::CFG_PORT_NUM), {5'h0, w60[6:4], 24'h0});
        chk_rd(ecl_pkg::ADDR_STATUS, 32'h0000_0B03);
        i_rom.send(8'h60, ~w60);
        chk_rd(cfa(0, ecl_pkg::CFG_LINK_STAT), {3'h0, w60[1], 28'h0});
        $display("test load done");
    endtask
    task t_reload;
        strap <= 1'b0;
        apb(1'b1, ecl_pkg::ADDR_CTRL, 32'h1);
        chk_rd(cfa(0, ecl_pkg::CFG_PM_CAP), 32'h0600_0000);
        chk_rd(ecl_pkg::ADDR_CTRL, 32'h0);
        $display("test reload done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pm = '{16'h00AB, 16'h5A00, 16'h0054, 16'hC300, 16'h00EF, 16'h3C00};
        do_reset(1'b0);
        t_empty();
        t_load();
        t_reload();
        finish_test();
    end
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule
